//--- design/bmiu_core.sv
// execution logic of the block move instruction, byte and word count forms
// assumes memory on core_clk answers a read in the cycle rd_req is high
// What this block does
// - while count nonzero, read byte at source, write it at destination
// - after each byte, both pointers plus one, count minus one
// - check count first; zero moves nothing; stop at zero, then finish
// - on-chip operands: eight states plus four per byte moved
// - byte form counts from low byte, word form from full register
`timescale 1ns/100ps
module bmiu_core
    import bmiu_pkg::*;
#(
    parameter int unsigned ADDR_W = bmiu_pkg::BMIU_ADDR_W,
    parameter int unsigned FIFO_DEPTH = bmiu_pkg::BMIU_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire bmiu_pkg::bmiu_form_t form,
    input wire logic [ADDR_W-1:0] source_pointer_in,
    input wire logic [ADDR_W-1:0] destination_pointer_in,
    input wire logic [bmiu_pkg::BMIU_COUNT_W-1:0] count_register_in,
    input wire logic [bmiu_pkg::BMIU_FLAGS_W-1:0] flags_in,
    output logic busy,
    output logic done,
    output logic [ADDR_W-1:0] source_pointer,
    output logic [ADDR_W-1:0] destination_pointer,
    output logic [bmiu_pkg::BMIU_COUNT_W-1:0] count_register,
    output logic [bmiu_pkg::BMIU_FLAGS_W-1:0] flags_out,
    output logic rd_req,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    output logic wr_req,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [7:0] wr_data,
    input wire logic wr_ready
);
    import bmiu_pkg::*;

    bmiu_state_t state_reg, state_next;
    bmiu_form_t form_reg, form_next;
    logic [2:0] phase_reg, phase_next;
    logic [ADDR_W-1:0] src_reg, src_next, dst_reg, dst_next;
    logic [BMIU_COUNT_W-1:0] cnt_reg, cnt_next;
    logic [BMIU_FLAGS_W-1:0] flags_reg, flags_next;
    logic busy_reg, busy_next, done_reg, done_next;
    logic rd_req_reg, rd_req_next, wr_req_reg, wr_req_next;
    logic [7:0] wr_data_reg, wr_data_next;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [7:0] fifo_out_data;
    logic count_zero;

    bmiu_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(rd_req_reg && rd_valid),
        .in_ready(fifo_in_ready),
        .in_data(rd_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // word form uses all 16 bits
    assign count_zero = (form_reg == BMIU_FORM_BYTE) ? (cnt_reg[7:0] == 8'h00)
                                                     : (cnt_reg == '0);
    assign fifo_pop = (state_reg == BMIU_WRITE) && fifo_out_valid && !wr_req_reg;

    always_comb begin
        state_next = state_reg;
        form_next = form_reg;
        phase_next = phase_reg;
        src_next = src_reg;
        dst_next = dst_reg;
        cnt_next = cnt_reg;
        flags_next = flags_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        rd_req_next = 1'b0;
        wr_req_next = wr_req_reg && !wr_ready;
        wr_data_next = wr_data_reg;
        unique case (state_reg)
            BMIU_IDLE: begin
                if (start) begin
                    state_next = BMIU_PRE;
                    form_next = form;
                    phase_next = BMIU_PHASE_RESET;
                    src_next = source_pointer_in;
                    dst_next = destination_pointer_in;
                    cnt_next = count_register_in;
                    flags_next = flags_in;
                    busy_next = 1'b1;
                end
            end
            BMIU_PRE: begin
                phase_next = phase_reg + 3'h1;
                if (phase_reg == BMIU_PHASE_LAST) begin
                    phase_next = BMIU_PHASE_RESET;
                    state_next = count_zero ? BMIU_POST : BMIU_READ;
                end
            end
            BMIU_READ: begin
                if (fifo_in_ready) begin
                    rd_req_next = 1'b1;
                    state_next = BMIU_CATCH;
                end
            end
            BMIU_CATCH: begin
                rd_req_next = !rd_valid;
                if (rd_valid) begin
                    state_next = BMIU_WRITE;
                end
            end
            BMIU_WRITE: begin
                if (fifo_pop) begin
                    wr_req_next = 1'b1;
                    wr_data_next = fifo_out_data;
                    state_next = BMIU_STEP;
                end
            end
            BMIU_STEP: begin
                if (!wr_req_reg || wr_ready) begin
                    src_next = src_reg + ADDR_W'(1);
                    dst_next = dst_reg + ADDR_W'(1);
                    if (form_reg == BMIU_FORM_BYTE) begin
                        cnt_next = {cnt_reg[15:8], cnt_reg[7:0] - 8'h01};
                    end else begin
                        cnt_next = cnt_reg - 16'h0001;
                    end
                    if ((form_reg == BMIU_FORM_BYTE) ? (cnt_reg[7:0] == 8'h01)
                                                     : (cnt_reg == 16'h0001)) begin
                        state_next = BMIU_POST;
                    end else begin
                        state_next = BMIU_READ;
                    end
                end
            end
            BMIU_POST: begin
                phase_next = phase_reg + 3'h1;
                if (phase_reg == BMIU_PHASE_LAST) begin
                    phase_next = BMIU_PHASE_RESET;
                    state_next = BMIU_IDLE;
                    busy_next = 1'b0;
                    done_next = 1'b1;
                end
            end
            default: begin
                state_next = BMIU_IDLE;
                busy_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= BMIU_IDLE;
            form_reg <= BMIU_FORM_BYTE;
            phase_reg <= BMIU_PHASE_RESET;
            src_reg <= '0;
            dst_reg <= '0;
            cnt_reg <= '0;
            flags_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            rd_req_reg <= 1'b0;
            wr_req_reg <= 1'b0;
            wr_data_reg <= BMIU_BYTE_RESET;
        end else begin
            state_reg <= state_next;
            form_reg <= form_next;
            phase_reg <= phase_next;
            src_reg <= src_next;
            dst_reg <= dst_next;
            cnt_reg <= cnt_next;
            flags_reg <= flags_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            rd_req_reg <= rd_req_next;
            wr_req_reg <= wr_req_next;
            wr_data_reg <= wr_data_next;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
    assign source_pointer = src_reg;
    assign destination_pointer = dst_reg;
    assign count_register = cnt_reg;
    assign flags_out = flags_reg;
    assign rd_req = rd_req_reg;
    assign rd_addr = src_reg;
    assign wr_req = wr_req_reg;
    assign wr_addr = dst_reg;
    assign wr_data = wr_data_reg;
endmodule

//--- common/bmiu_pkg.sv
// package for the block move instruction unit
// assumes one core clock and one asynchronous active-low reset
package bmiu_pkg;
    // fixed overhead split before and after the copy loop
    localparam int unsigned BMIU_PRE_STATES = 4;
    localparam int unsigned BMIU_POST_STATES = 4;
    localparam int unsigned BMIU_FIXED_STATES = BMIU_PRE_STATES + BMIU_POST_STATES;
    localparam int unsigned BMIU_STATES_PER_BYTE = 4;
    localparam logic [2:0] BMIU_PHASE_W1 = 3'h1;
    localparam logic [2:0] BMIU_PHASE_LAST = 3'h3;
    // widths and values after reset
    localparam int unsigned BMIU_ADDR_W = 24;
    localparam int unsigned BMIU_COUNT_W = 16;
    localparam int unsigned BMIU_FLAGS_W = 8;
    localparam int unsigned BMIU_FIFO_DEPTH = 16;
    localparam logic [2:0] BMIU_PHASE_RESET = 3'h0;
    localparam logic [7:0] BMIU_BYTE_RESET = 8'h00;

    typedef enum logic [0:0] {
        BMIU_FORM_BYTE = 1'b0,
        BMIU_FORM_WORD = 1'b1
    } bmiu_form_t;

    typedef enum logic [2:0] {
        BMIU_IDLE = 3'b000,
        BMIU_PRE = 3'b001,
        BMIU_READ = 3'b010,
        BMIU_CATCH = 3'b011,
        BMIU_WRITE = 3'b100,
        BMIU_STEP = 3'b101,
        BMIU_POST = 3'b110
    } bmiu_state_t;
endpackage

//--- design/bmiu_fifo.sv
// byte buffer between the read and write halves of the copy loop
// assumes both sides on core_clk; valid/ready handshake on each side
`timescale 1ns/100ps
module bmiu_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [PTR_W:0] fill_reg, fill_next;
    logic push, pop;

    assign in_ready = (fill_reg != (PTR_W+1)'(DEPTH));
    assign out_valid = (fill_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        fill_next = fill_reg;
        if (push) begin
            wr_ptr_next = (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
        end
        if (push && !pop) begin
            fill_next = fill_reg + 1'b1;
        end else if (pop && !push) begin
            fill_next = fill_reg - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            fill_reg <= fill_next;
        end
    end

    // storage only, no reset needed
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end
endmodule

//--- bench/bmiu_core_asserts.sv
// port assertions for the block move unit
// assumes bind into bmiu_core, single clock domain
`timescale 1ns/100ps
module bmiu_core_asserts
    import bmiu_pkg::*;
#(parameter int unsigned ADDR_W = 24) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire bmiu_pkg::bmiu_form_t form,
    input wire logic [15:0] count_register_in,
    input wire logic [7:0] flags_in,
    input wire logic busy,
    input wire logic done,
    input wire logic [ADDR_W-1:0] source_pointer,
    input wire logic [ADDR_W-1:0] destination_pointer,
    input wire logic [15:0] count_register,
    input wire logic [7:0] flags_out,
    input wire logic rd_req,
    input wire logic [ADDR_W-1:0] rd_addr,
    input wire logic rd_valid,
    input wire logic wr_req,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_ready
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] n_eff;
    logic taken;
    assign n_eff = (form == BMIU_FORM_WORD) ? count_register_in : {8'h00, count_register_in[7:0]};
    assign taken = start && !busy;
    sequence s_tail;
        !busy && done;
    endsequence
    sequence s_fixed;
        busy[*8];
    endsequence
    property p_zero;
        taken && n_eff == 16'h0000 |=> (busy && !rd_req && !wr_req)[*8] ##1 s_tail;
    endproperty
    property p_one;
        taken && n_eff == 16'h0001 |=> s_fixed ##1 busy[*4] ##1 s_tail;
    endproperty
    property p_rd_hold;
        rd_req && !rd_valid |=> rd_req && $stable(rd_addr);
    endproperty
    property p_wr_hold;
        wr_req && !wr_ready |=> wr_req && $stable(wr_data) && $stable(wr_addr);
    endproperty
    property p_step;
        wr_req && wr_ready |=> source_pointer == $past(source_pointer) + 1
            && destination_pointer == $past(destination_pointer) + 1
            && count_register[7:0] == $past(count_register[7:0]) - 8'h01;
    endproperty
    property p_flags;
        taken |=> flags_out == $past(flags_in);
    endproperty
    property p_flags_hold;
        busy |=> $stable(flags_out);
    endproperty
    property p_done;
        $fell(busy) |-> done ##1 !done;
    endproperty
    a_zero: assert property (p_zero) else $error("zero count run wrong");
    a_one: assert property (p_one) else $error("single byte timing wrong");
    a_rd_hold: assert property (p_rd_hold) else $error("read not held");
    a_wr_hold: assert property (p_wr_hold) else $error("write not held");
    a_step: assert property (p_step) else $error("pointer step wrong");
    a_flags: assert property (p_flags) else $error("flags not captured");
    a_flags_hold: assert property (p_flags_hold) else $error("flags changed");
    a_done: assert property (p_done) else $error("done pulse wrong");
endmodule
bind bmiu_core bmiu_core_asserts #(.ADDR_W(ADDR_W)) bmiu_core_asserts_i (
    .core_clk(core_clk), .rst_n(rst_n), .start(start), .form(form),
    .count_register_in(count_register_in), .flags_in(flags_in), .busy(busy), .done(done),
    .source_pointer(source_pointer), .destination_pointer(destination_pointer),
    .count_register(count_register), .flags_out(flags_out), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_valid(rd_valid), .wr_req(wr_req), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_ready(wr_ready));

//--- bench/bmiu_mem_model.sv
// memory model for the block move unit, prompt or stalling
// assumes requests on core_clk; read data is address xor salt
`timescale 1ns/100ps
module bmiu_mem_model #(parameter int unsigned ADDR_W = 24) (
    input wire logic core_clk,
    input wire logic slow,
    input wire logic [7:0] salt,
    input wire logic rd_req,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic rd_valid,
    output logic [7:0] rd_data,
    input wire logic wr_req,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    output logic wr_ready
);
    logic ph = 1'b0;
    logic [7:0] wmem [256];
    int nwr = 0;
    // written bytes kept for the bench
    always @(posedge core_clk) begin
        ph <= ~ph;
        if (wr_req && wr_ready) begin
            wmem[wr_addr[7:0]] <= wr_data;
            nwr <= nwr + 1;
        end
    end
    // stall every other cycle when slow; junk data when not valid
    assign rd_valid = rd_req && (!slow || ph);
    assign rd_data = rd_valid ? (rd_addr[7:0] ^ salt) : ~(rd_addr[7:0] ^ salt) ^ {8{ph}};
    assign wr_ready = !slow || ph;
endmodule

//--- bench/tb.sv
// testbench for the block move unit
// assumes memory model beside the core, 10 MHz clock
`timescale 1ns/100ps
module tb;
    import bmiu_pkg::*;
    localparam logic [23:0] SRC = 24'h000300;
    localparam logic [23:0] DST = 24'h000500;
    logic core_clk = 1'b0, rst_n = 1'b0, start = 1'b0, slow = 1'b0;
    bmiu_form_t form = BMIU_FORM_BYTE;
    logic [15:0] count_register_in = 16'h0000;
    logic [7:0] flags_in = 8'h00, salt = 8'h00;
    logic busy, done, rd_req, rd_valid, wr_req, wr_ready;
    logic [23:0] source_pointer, destination_pointer, rd_addr, wr_addr;
    logic [15:0] count_register;
    logic [7:0] flags_out, rd_data, wr_data;
    int n_mismatch = 0, compares = 0, n_cyc = 0;
    bmiu_core bmiu_core_i (.core_clk(core_clk), .rst_n(rst_n), .start(start), .form(form),
        .source_pointer_in(SRC), .destination_pointer_in(DST),
        .count_register_in(count_register_in), .flags_in(flags_in), .busy(busy), .done(done),
        .source_pointer(source_pointer), .destination_pointer(destination_pointer),
        .count_register(count_register), .flags_out(flags_out), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data), .wr_req(wr_req),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready));
    bmiu_mem_model bmiu_mem_model_i (.core_clk(core_clk), .slow(slow), .salt(salt),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
        .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready));
    initial forever #50 core_clk = ~core_clk;
    task automatic end_of_test();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        n_cyc <= n_cyc + 1;
        if (n_cyc == 10000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one instruction, driven from the next edge, checked at its end
    task automatic go(input bmiu_form_t f, input logic [15:0] c, input int n, input logic slw,
        input int exp_cyc, input logic poke);
        int cyc;
        int nw0;
        logic [31:0] exp_cnt;
        logic [7:0] exp_b;
        nw0 = bmiu_mem_model_i.nwr;
        @(posedge core_clk);
        salt <= salt + 8'h1d;
        slow <= slw;
        form <= f;
        count_register_in <= c;
        flags_in <= c[7:0] ^ 8'h96;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        #1;
        cyc = 0;
        while (busy === 1'b1 && cyc < 4000) begin
            cyc++;
            @(posedge core_clk);
            start <= poke && cyc == 3;
            #1;
        end
        if (exp_cyc > 0) chk("busy cycles", exp_cyc, cyc);
        chk("done", 1, done);
        chk("source", SRC + n, source_pointer);
        chk("destination", DST + n, destination_pointer);
        exp_cnt = (f == BMIU_FORM_WORD) ? 32'h0 : {16'h0, c[15:8], 8'h00};
        chk("count", exp_cnt, count_register);
        chk("flags", c[7:0] ^ 8'h96, flags_out);
        chk("writes", n, bmiu_mem_model_i.nwr - nw0);
        for (int i = 0; i < n; i++) begin
            exp_b = (SRC[7:0] + 8'(i)) ^ salt;
            chk("data", exp_b, bmiu_mem_model_i.wmem[DST[7:0] + 8'(i)]);
        end
    endtask
    task automatic t_zero();
        go(BMIU_FORM_BYTE, 16'h3400, 0, 1'b0, 8, 1'b0);
        go(BMIU_FORM_WORD, 16'h0000, 0, 1'b0, 8, 1'b0);
        $display("test zero count ended");
    endtask
    task automatic t_one();
        go(BMIU_FORM_BYTE, 16'h7701, 1, 1'b0, 12, 1'b0);
        go(BMIU_FORM_WORD, 16'h0001, 1, 1'b0, 12, 1'b0);
        $display("test single byte ended");
    endtask
    task automatic t_long();
        go(BMIU_FORM_BYTE, 16'h00ff, 255, 1'b0, 1028, 1'b1);
        $display("test long byte form with ignored start ended");
    endtask
    task automatic t_word();
        go(BMIU_FORM_WORD, 16'h0100, 256, 1'b1, 0, 1'b0);
        $display("test word form with stalls ended");
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        t_zero();
        t_one();
        t_long();
        t_word();
        end_of_test();
    end
endmodule
